/* core/ccc_pkg.sv */
// constants, field layout and codes for the capture/compare channel configuration block
package ccc_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NCH    = 4;
	localparam int AUX_W  = 6;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  MODE_OFS    = 8'h1C;
	localparam logic [7:0]  ENPOL_OFS   = 8'h20;
	localparam logic [7:0]  AUX_OFS     = 8'h40;
	localparam logic [15:0] MODE_RST    = 16'h0000;
	localparam logic [15:0] ENPOL_RST   = 16'h0000;
	localparam logic [5:0]  AUX_RST     = 6'h00;
	localparam logic [15:0] ENPOL_WMASK = 16'h3FFF;
	localparam logic [15:0] READ_IDLE   = 16'h0000;

	// ------------------------------------------------------------
	// enable/polarity layout: four bits per channel
	// ------------------------------------------------------------
	localparam int STRIDE  = 4;
	localparam int EN_B    = 0;
	localparam int POL_B   = 1;
	localparam int CEN_B   = 2;
	localparam int CPOL_B  = 3;
	localparam int COMP_LO = 12;

	// ------------------------------------------------------------
	// mode register fields, index 0 is channel 3, index 1 channel 4
	// ------------------------------------------------------------
	localparam int DIR_LSB  [0:1] = '{0, 8};
	localparam int FAST_B   [0:1] = '{2, 10};
	localparam int PRE_B    [0:1] = '{3, 11};
	localparam int CMP_LSB  [0:1] = '{4, 12};
	localparam int CLR_B    [0:1] = '{7, 15};
	localparam int DIV_LSB  [0:1] = '{2, 10};
	localparam int FILT_LSB [0:1] = '{4, 12};
	localparam logic [15:0] DIR_MASK [0:1] = '{16'h0003, 16'h0300};

	// ------------------------------------------------------------
	// auxiliary control register bits
	// ------------------------------------------------------------
	localparam int COMMUTATION_PRELOAD_CTRL_B   = 0;
	localparam int LOCK_LSB = 1;
	localparam int MOE_B    = 3;
	localparam int RUN_OFFSTATE_SEL_B   = 4;
	localparam int IDLE_OFFSTATE_SEL_B   = 5;
	localparam logic [1:0] LOCK_POL = 2'h2;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [1:0] DIR_OUT   = 2'h0;
	localparam logic [1:0] DIR_OWN   = 2'h1;
	localparam logic [1:0] DIR_CROSS = 2'h2;
	localparam logic [1:0] DIR_TRIG  = 2'h3;
	localparam logic [2:0] CMP_FROZEN   = 3'h0;
	localparam logic [2:0] CMP_SET      = 3'h1;
	localparam logic [2:0] CMP_CLR      = 3'h2;
	localparam logic [2:0] CMP_TOGGLE   = 3'h3;
	localparam logic [2:0] CMP_FORCE_LO = 3'h4;
	localparam logic [2:0] CMP_FORCE_HI = 3'h5;
	localparam logic [2:0] CMP_PWM1     = 3'h6;
	localparam logic [2:0] CMP_PWM2     = 3'h7;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_RSVD = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [2:0] DIV_LIMIT [0:3] = '{3'h0, 3'h1, 3'h3, 3'h7};
endpackage

/* core/ccc_chan_out.sv */
// output stage of one channel: main and complementary pin drive
`timescale 1ns/1ps
module ccc_chan_out
(
	input  wire logic mclk,      // kernel clock
	input  wire logic rst_n,     // async reset, active low
	input  wire logic is_out,    // channel configured as output
	input  wire logic ref_wave,  // reference waveform, active high
	input  wire logic en,        // active main enable
	input  wire logic pol,       // active main polarity
	input  wire logic cen,       // active complementary enable
	input  wire logic cpol,      // active complementary polarity
	input  wire logic main_output_enable,       // main output enable
	input  wire logic run_offstate_sel,      // run off-state select
	input  wire logic idle_offstate_sel,      // idle off-state select
	output logic      main_out,  // main pin level
	output logic      main_oe_n, // main pin enable, low drives
	output logic      comp_out,  // complementary pin level
	output logic      comp_oe_n  // complementary pin enable, low drives
);
	// ------------------------------------------------------------
	// drive decision
	// ------------------------------------------------------------
	// off-state drives the inactive level, which is the polarity bit
	wire main_drive = is_out & (main_output_enable ? (en | (run_offstate_sel & cen)) : (idle_offstate_sel & (en | cen)));
	wire comp_drive = is_out & (main_output_enable ? (cen | (run_offstate_sel & en)) : (idle_offstate_sel & (en | cen)));
	wire main_lvl   = (main_output_enable & en) ? (ref_wave ^ pol) : pol;
	// with both enabled the complementary pin carries the inverted reference
	wire comp_lvl   = (main_output_enable & cen) ? ((en ? ~ref_wave : ref_wave) ^ cpol) : cpol;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			main_out  <= 1'b0;
			main_oe_n <= 1'b1;
			comp_out  <= 1'b0;
			comp_oe_n <= 1'b1;
		end
		else
		begin
			main_out  <= main_lvl;
			main_oe_n <= ~main_drive;
			comp_out  <= comp_lvl;
			comp_oe_n <= ~comp_drive;
		end
	end
endmodule // ccc_chan_out

/* core/ccc_config.sv */
// capture/compare channel configuration: mode and enable registers, capture gating, pin drive
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module ccc_config
(
	input  wire logic        mclk,                   // kernel clock, 125 MHz
	input  wire logic        rst_n,                  // async reset, active low
	input  wire logic [7:0]  addr,                   // register byte address
	input  wire logic [15:0] wdata,                  // write data
	input  wire logic        wr_en,                  // write strobe
	input  wire logic        rd_en,                  // read strobe
	output logic      [15:0] rdata,                  // read data, cycle after rd_en
	input  wire logic [3:0]  ch12_direction,         // channel 2 and 1 direction fields
	input  wire logic [3:0]  ref_wave,               // reference waveforms per channel
	input  wire logic        com_event,              // commutation event pulse
	input  wire logic        input_line_three,       // pin, asynchronous
	input  wire logic        input_line_four,        // pin, asynchronous
	input  wire logic        internal_trigger_source,// internal trigger level
	output logic      [2:0]  ch3_compare_mode,       // channel 3 compare mode
	output logic      [2:0]  ch4_compare_mode,       // channel 4 compare mode
	output logic      [3:0]  ch3_input_filter,       // channel 3 filter setting
	output logic      [3:0]  ch4_input_filter,       // channel 4 filter setting
	output logic      [1:0]  ref_clear_en,           // clear enables, ch4 ch3
	output logic      [1:0]  compare_preload_en,     // preload enables, ch4 ch3
	output logic      [1:0]  fast_trigger_en,        // fast enables, ch4 ch3
	output logic      [15:0] active_enable_polarity, // active enable/polarity copy
	output logic      [3:0]  capture_en,             // capture permitted per channel
	output logic      [1:0]  capture_strobe,         // capture pulse, ch4 ch3
	output logic      [3:0]  chan_out,               // main pin levels
	output logic      [3:0]  chan_out_oe_n,          // main pin enables, low drives
	output logic      [2:0]  comp_out,               // complementary pin levels
	output logic      [2:0]  comp_out_oe_n           // complementary pin enables
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] channel34_mode_config;
	logic [15:0] channel_enable_polarity;
	logic [15:0] enpol_active;
	logic [5:0]  aux_ctrl;
	logic [1:0]  line_meta;
	logic [1:0]  line_sync;
	logic [1:0]  line_prev;
	logic        trig_prev;
	logic [2:0]  ev_cnt [0:1];

	wire        mode_hit  = addr == ccc_pkg::MODE_OFS;
	wire        enpol_hit = addr == ccc_pkg::ENPOL_OFS;
	wire        aux_hit   = addr == ccc_pkg::AUX_OFS;
	wire        commutation_preload_ctrl      = aux_ctrl[ccc_pkg::COMMUTATION_PRELOAD_CTRL_B];
	wire [1:0]  lock_lvl  = aux_ctrl[ccc_pkg::LOCK_LSB +: 2];
	wire        pol_lock  = lock_lvl >= ccc_pkg::LOCK_POL;
	wire [7:0]  chan_dir  = {channel34_mode_config[ccc_pkg::DIR_LSB[1] +: 2],
				channel34_mode_config[ccc_pkg::DIR_LSB[0] +: 2], ch12_direction};

	// ------------------------------------------------------------
	// write protection
	// ------------------------------------------------------------
	// direction stays put while the channel is on, so a running capture cannot be remapped
	wire        ch3_on   = channel_enable_polarity[2 * ccc_pkg::STRIDE + ccc_pkg::EN_B];
	wire        ch4_on   = channel_enable_polarity[3 * ccc_pkg::STRIDE + ccc_pkg::EN_B];
	wire [15:0] dir_keep = ({16{ch3_on}} & ccc_pkg::DIR_MASK[0])
				| ({16{ch4_on}} & ccc_pkg::DIR_MASK[1]);
	wire [15:0] next_mode = (wdata & ~dir_keep) | (channel34_mode_config & dir_keep);
	wire [15:0] enpol_keep;

	genvar gi;
	generate
		for (gi = 0; gi < ccc_pkg::NCH; gi++)
		begin : g_lock
			wire is_out = chan_dir[2 * gi +: 2] == ccc_pkg::DIR_OUT;
			assign enpol_keep[gi * ccc_pkg::STRIDE + ccc_pkg::EN_B]   = 1'b0;
			assign enpol_keep[gi * ccc_pkg::STRIDE + ccc_pkg::POL_B]  = pol_lock;
			assign enpol_keep[gi * ccc_pkg::STRIDE + ccc_pkg::CEN_B]  = 1'b0;
			assign enpol_keep[gi * ccc_pkg::STRIDE + ccc_pkg::CPOL_B] = pol_lock & is_out;
		end
	endgenerate

	wire [15:0] next_enpol = ((wdata & ~enpol_keep) | (channel_enable_polarity & enpol_keep))
				& ccc_pkg::ENPOL_WMASK;

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel34_mode_config   <= ccc_pkg::MODE_RST;
			channel_enable_polarity <= ccc_pkg::ENPOL_RST;
			aux_ctrl                <= ccc_pkg::AUX_RST;
		end
		else if (wr_en)
		begin
			if (mode_hit)
				channel34_mode_config <= next_mode;
			if (enpol_hit)
				channel_enable_polarity <= next_enpol;
			if (aux_hit)
				aux_ctrl <= wdata[ccc_pkg::AUX_W - 1:0];
		end
	end

	// ------------------------------------------------------------
	// active copies
	// ------------------------------------------------------------
	// complementary channels wait for commutation when preload is on; channel 4 follows at once
	wire        act_load = ~commutation_preload_ctrl | com_event;
	wire [15:0] next_active = {channel_enable_polarity[15:ccc_pkg::COMP_LO],
				act_load ? channel_enable_polarity[ccc_pkg::COMP_LO - 1:0]
				: enpol_active[ccc_pkg::COMP_LO - 1:0]};

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			enpol_active <= ccc_pkg::ENPOL_RST;
		else
			enpol_active <= next_active;
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	wire [15:0] read_word = mode_hit ? channel34_mode_config
				: enpol_hit ? channel_enable_polarity
				: aux_hit ? {{(16 - ccc_pkg::AUX_W){1'b0}}, aux_ctrl}
				: ccc_pkg::READ_IDLE;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= ccc_pkg::READ_IDLE;
		else if (rd_en)
			rdata <= read_word;
		else
			rdata <= ccc_pkg::READ_IDLE;
	end

	// ------------------------------------------------------------
	// mode fields out
	// ------------------------------------------------------------
	assign ch3_compare_mode   = channel34_mode_config[ccc_pkg::CMP_LSB[0] +: 3];
	assign ch4_compare_mode   = channel34_mode_config[ccc_pkg::CMP_LSB[1] +: 3];
	assign ch3_input_filter   = channel34_mode_config[ccc_pkg::FILT_LSB[0] +: 4];
	assign ch4_input_filter   = channel34_mode_config[ccc_pkg::FILT_LSB[1] +: 4];
	assign ref_clear_en       = {channel34_mode_config[ccc_pkg::CLR_B[1]],
				channel34_mode_config[ccc_pkg::CLR_B[0]]};
	assign compare_preload_en = {channel34_mode_config[ccc_pkg::PRE_B[1]],
				channel34_mode_config[ccc_pkg::PRE_B[0]]};
	assign fast_trigger_en    = {channel34_mode_config[ccc_pkg::FAST_B[1]],
				channel34_mode_config[ccc_pkg::FAST_B[0]]};
	assign active_enable_polarity = enpol_active;

	// ------------------------------------------------------------
	// input lines
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_meta <= 2'h0;
			line_sync <= 2'h0;
			line_prev <= 2'h0;
			trig_prev <= 1'b0;
		end
		else
		begin
			line_meta <= {input_line_four, input_line_three};
			line_sync <= line_meta;
			line_prev <= line_sync;
			trig_prev <= internal_trigger_source;
		end
	end

	wire [1:0] line_rise = line_sync & ~line_prev;
	wire [1:0] line_fall = ~line_sync & line_prev;
	wire       trig_rise = internal_trigger_source & ~trig_prev;
	wire       trig_fall = ~internal_trigger_source & trig_prev;

	// ------------------------------------------------------------
	// capture path, channels 3 and 4
	// ------------------------------------------------------------
	// channel 4 has no complementary polarity bit, so it cannot select both edges
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cap
			wire [1:0] dir  = channel34_mode_config[ccc_pkg::DIR_LSB[gi] +: 2];
			wire [1:0] div  = channel34_mode_config[ccc_pkg::DIV_LSB[gi] +: 2];
			wire [1:0] pair = {enpol_active[(gi + 2) * ccc_pkg::STRIDE + ccc_pkg::CPOL_B],
					enpol_active[(gi + 2) * ccc_pkg::STRIDE + ccc_pkg::POL_B]};
			wire rise = (dir == ccc_pkg::DIR_OWN) ? line_rise[gi]
					: (dir == ccc_pkg::DIR_CROSS) ? line_rise[1 - gi] : trig_rise;
			wire fall = (dir == ccc_pkg::DIR_OWN) ? line_fall[gi]
					: (dir == ccc_pkg::DIR_CROSS) ? line_fall[1 - gi] : trig_fall;
			// the reserved pair is treated as rising edge
			wire evt = (pair == ccc_pkg::EDGE_BOTH) ? (rise | fall)
					: (pair == ccc_pkg::EDGE_FALL) ? fall : rise;
			// a divider lowered mid-count wraps at once instead of running to seven
			wire last = ev_cnt[gi] >= ccc_pkg::DIV_LIMIT[div];
			wire [2:0] next_cnt = last ? 3'h0 : ev_cnt[gi] + 3'h1;

			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					ev_cnt[gi]         <= 3'h0;
					capture_strobe[gi] <= 1'b0;
				end
				else if (!capture_en[gi + 2])
				begin
					ev_cnt[gi]         <= 3'h0;
					capture_strobe[gi] <= 1'b0;
				end
				else
				begin
					ev_cnt[gi]         <= evt ? next_cnt : ev_cnt[gi];
					capture_strobe[gi] <= evt & last;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// per-channel gating and pin drive
	// ------------------------------------------------------------
	wire [3:0] ref_eff;
	wire [3:0] comp_lvl_all;
	wire [3:0] comp_oe_all;

	assign ref_eff[1:0] = ref_wave[1:0];

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ref
			wire [2:0] cmp = channel34_mode_config[ccc_pkg::CMP_LSB[gi] +: 3];
			assign ref_eff[gi + 2] = (cmp == ccc_pkg::CMP_FORCE_LO) ? 1'b0
					: (cmp == ccc_pkg::CMP_FORCE_HI) ? 1'b1 : ref_wave[gi + 2];
		end

		for (gi = 0; gi < ccc_pkg::NCH; gi++)
		begin : g_chan
			wire is_out = chan_dir[2 * gi +: 2] == ccc_pkg::DIR_OUT;
			assign capture_en[gi] = ~is_out & enpol_active[gi * ccc_pkg::STRIDE + ccc_pkg::EN_B];
			ccc_chan_out u_out
			(
				.mclk      (mclk),
				.rst_n     (rst_n),
				.is_out    (is_out),
				.ref_wave  (ref_eff[gi]),
				.en        (enpol_active[gi * ccc_pkg::STRIDE + ccc_pkg::EN_B]),
				.pol       (enpol_active[gi * ccc_pkg::STRIDE + ccc_pkg::POL_B]),
				.cen       (enpol_active[gi * ccc_pkg::STRIDE + ccc_pkg::CEN_B]),
				.cpol      (enpol_active[gi * ccc_pkg::STRIDE + ccc_pkg::CPOL_B]),
				.main_output_enable       (aux_ctrl[ccc_pkg::MOE_B]),
				.run_offstate_sel      (aux_ctrl[ccc_pkg::RUN_OFFSTATE_SEL_B]),
				.idle_offstate_sel      (aux_ctrl[ccc_pkg::IDLE_OFFSTATE_SEL_B]),
				.main_out  (chan_out[gi]),
				.main_oe_n (chan_out_oe_n[gi]),
				.comp_out  (comp_lvl_all[gi]),
				.comp_oe_n (comp_oe_all[gi])
			);
		end
	endgenerate

	// channel 4 complementary stage outputs are dropped; comp_out and comp_out_oe_n carry channels 1 to 3 only
	assign comp_out      = comp_lvl_all[2:0];
	assign comp_out_oe_n = comp_oe_all[2:0];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_mode_wr_on3;
		wr_en && mode_hit && ch3_on;
	endsequence

	sequence s_mode_wr_on4;
		wr_en && mode_hit && ch4_on;
	endsequence

	ch3_dir_hold_a:
	assert property (s_mode_wr_on3 |=> $stable(channel34_mode_config[1:0]))
		else $error("channel 3 direction changed while enabled");

	ch4_dir_hold_a:
	assert property (s_mode_wr_on4 |=> $stable(channel34_mode_config[9:8]))
		else $error("channel 4 direction changed while enabled");

	enpol_reserved_a:
	assert property (channel_enable_polarity[15:14] == 2'h0 && enpol_active[15:14] == 2'h0)
		else $error("reserved enable bits not zero");

	pol_locked_a:
	assert property (wr_en && enpol_hit && pol_lock |=>
		channel_enable_polarity[13] == $past(channel_enable_polarity[13])
		&& channel_enable_polarity[1] == $past(channel_enable_polarity[1]))
		else $error("polarity written under lock");

	commut_hold_a:
	assert property (commutation_preload_ctrl && !com_event |=> enpol_active[11:0] == $past(enpol_active[11:0]))
		else $error("active bits moved without commutation");

	commut_load_a:
	assert property (com_event |=> enpol_active == $past(channel_enable_polarity))
		else $error("commutation did not load active bits");

	mode_read_a:
	assert property (rd_en && mode_hit |=> rdata == $past(channel34_mode_config))
		else $error("mode register read mismatch");

	gated_strobe_a:
	assert property (capture_strobe[0] |-> $past(capture_en[2]))
		else $error("capture strobe while capture disabled");

	div_every_a:
	assert property (capture_en[2] && channel34_mode_config[3:2] == 2'h0 && $past(capture_en[2])
		&& g_cap[0].evt |=> capture_strobe[0])
		else $error("undivided capture missed an edge");

	force_hi_a:
	assert property (ch3_compare_mode == ccc_pkg::CMP_FORCE_HI && chan_dir[5:4] == ccc_pkg::DIR_OUT
		&& enpol_active[8] && aux_ctrl[ccc_pkg::MOE_B] |=> !chan_out_oe_n[2]
		&& chan_out[2] == !$past(enpol_active[9]))
		else $error("forced active level not driven");
endmodule // ccc_config

/* testbench/ccc_pin_model.sv */
// pin-side model: capture pins three and four and the internal trigger level
`timescale 1ns/1ps
module ccc_pin_model
(
	input  wire logic       mclk,       // kernel clock
	input  wire logic [1:0] pick,       // 1 pin three, 2 pin four, 3 trigger
	input  wire logic       go,         // start one high pulse
	output logic            line_three, // capture pin three
	output logic            line_four,  // capture pin four
	output logic            trig,       // internal trigger level
	output logic            busy        // pulse in progress
);
	initial
	begin
		{line_three, line_four, trig, busy} = 4'h0;
		forever
		begin
			@(posedge mclk);
			if (go)
			begin
				busy = 1'b1;
				// pins are asynchronous, so they move away from the edge
				#3;
				{line_three, line_four, trig} = {pick == 2'h1, pick == 2'h2, pick == 2'h3};
				repeat (6) @(posedge mclk);
				#3;
				{line_three, line_four, trig} = 3'h0;
				repeat (6) @(posedge mclk);
				busy = 1'b0;
			end
		end
	end
endmodule // ccc_pin_model

/* testbench/capture_compare_channel_config_test.sv */
// self-checking bench for the channel configuration block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h want %h", $time, g, e); end end
module capture_compare_channel_config_test;
	logic        mclk, rst_n, wr_en, rd_en, com_event, go, l3, l4, trg, busy;
	logic [7:0]  addr;
	logic [15:0] wdata, r, rv, w, aep;
	logic [3:0]  dir12, ref_wave, cap_en, c_out, c_oe_n, f3, f4;
	logic [2:0]  m3, m4, n_out, n_oe_n;
	logic [1:0]  clr, pre, fast, strobe, pick;
	int          n_fail, checked, cnt3, cnt4, k, ch, d, p;

	ccc_config i_ccc_config (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(r), .ch12_direction(dir12), .ref_wave(ref_wave), .com_event(com_event),
		.input_line_three(l3), .input_line_four(l4), .internal_trigger_source(trg),
		.ch3_compare_mode(m3), .ch4_compare_mode(m4), .ch3_input_filter(f3), .ch4_input_filter(f4),
		.ref_clear_en(clr), .compare_preload_en(pre), .fast_trigger_en(fast), .active_enable_polarity(aep),
		.capture_en(cap_en), .capture_strobe(strobe), .chan_out(c_out), .chan_out_oe_n(c_oe_n),
		.comp_out(n_out), .comp_out_oe_n(n_oe_n));
	ccc_pin_model i_ccc_pin_model (.mclk(mclk), .pick(pick), .go(go), .line_three(l3), .line_four(l4),
		.trig(trg), .busy(busy));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cnt3 += int'(strobe[0] === 1'b1);
		cnt4 += int'(strobe[1] === 1'b1);
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		v = r;
	endtask
	task automatic cfg(input logic [15:0] mode, input logic [15:0] en);
		wr(8'h20, 16'h0000);
		wr(8'h1C, mode);
		wr(8'h20, en);
		repeat (3) @(posedge mclk);
		cnt3 = 0;
		cnt4 = 0;
	endtask
	task automatic pulse(input logic [1:0] s);
		int n;
		@(posedge mclk);
		pick <= s;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		#1;
		for (n = 0; busy === 1'b1 && n < 40; n++) @(posedge mclk);
		if (n == 40)
		begin
			n_fail++;
			close_out();
		end
		repeat (2) @(posedge mclk);
	endtask
	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	function automatic int src(input int c, input int s);
		return (s == 3) ? 3 : (((s == 1) ^ (c == 4)) ? 1 : 2);
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{wr_en, rd_en, com_event, go, rst_n} = 5'h00;
		{addr, wdata, dir12, ref_wave, pick} = 34'h0;
		{n_fail, checked} = 0;
		k = $urandom(32'h887A);
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h1C, w); `CHK(w, 16'h0000)
		rd(8'h20, w); `CHK(w, 16'h0000)
		rd(8'h10, w); `CHK(w, 16'h0000)
		repeat (8)
		begin
			w = 16'($urandom);
			ref_wave <= 4'($urandom);
			wr(8'h20, 16'h0000);
			wr(8'h1C, w);
			rd(8'h1C, rv); `CHK(rv, w)
			`CHK({clr, m4, m3, pre, fast}, {w[15], w[7], w[14:12], w[6:4], w[11], w[3], w[10], w[2]})
			`CHK({f4, f3}, {w[15:12], w[7:4]})
			w = 16'($urandom);
			wr(8'h20, w);
			rd(8'h20, rv); `CHK(rv, w & 16'h3FFF)
			`CHK(aep, w & 16'h3FFF)
		end
		cfg(16'h0101, 16'h1100);
		wr(8'h1C, 16'h0202);
		rd(8'h1C, w); `CHK(w, 16'h0101)
		wr(8'h20, 16'h1000);
		wr(8'h1C, 16'h0303);
		rd(8'h1C, w); `CHK(w, 16'h0103)
		dir12 <= 4'h4;
		cfg(16'h0000, 16'h0000);
		for (k = 1; k < 4; k++)
		begin
			wr(8'h40, 16'h0000);
			wr(8'h20, 16'h0000);
			wr(8'h40, 16'(k << 1));
			wr(8'h20, 16'h3FFF);
			rd(8'h20, w); `CHK(w, (k >= 2) ? 16'h15D5 : 16'h3FFF)
		end
		wr(8'h40, 16'h0000);
		wr(8'h20, 16'h0000);
		wr(8'h40, 16'h0001);
		wr(8'h20, 16'h1111);
		settle(); `CHK(aep, 16'h1000)
		@(posedge mclk);
		com_event <= 1'b1;
		@(posedge mclk);
		com_event <= 1'b0;
		settle(); `CHK(aep, 16'h1111)
		wr(8'h40, 16'h0000);
		// each direction code counts only pulses from its mapped source: own pin, crossed pin or trigger
		for (k = 0; k < 18; k++)
		begin
			ch = 3 + k / 9;
			d = k / 3 % 3 + 1;
			p = k % 3 + 1;
			cfg((ch == 3) ? 16'(d) : 16'(d << 8), (ch == 3) ? 16'h0100 : 16'h1000);
			pulse(2'(p));
			`CHK((ch == 3) ? cnt3 : cnt4, int'(p == src(ch, d)))
		end
		// reserved pair 10 and encoder mode never used
		for (k = 0; k < 7; k++)
		begin
			cfg(16'(1 | ((k & 3) << 2)) & ((k < 4) ? 16'hFFFF : 16'h0003),
				(k == 4) ? 16'h0B00 : (k == 5) ? 16'h0300 : (k == 6) ? 16'h0000 : 16'h0100);
			`CHK(cap_en[2], 1'(k != 6))
			repeat (8) pulse(2'h1);
			`CHK(cnt3, (k < 4) ? (8 >> k) : (k == 4) ? 16 : (k == 5) ? 8 : 0)
		end
		dir12 <= 4'h0;
		wr(8'h40, 16'h0008);
		for (k = 0; k < 8; k++)
		begin
			ref_wave <= {3'h0, k[2]};
			cfg(16'h0000, {12'h0, k[1], 1'b0, k[0], 1'b1});
			#1;
			`CHK({c_out[0], c_oe_n[0], n_oe_n[0]}, {k[2] ^ k[0], 2'h1})
			cfg(16'h0000, {12'h0, k[1], 1'b1, k[0], 1'b0});
			#1;
			`CHK({n_out[0], n_oe_n[0], c_oe_n[0]}, {k[2] ^ k[1], 2'h1})
		end
		for (k = 4; k < 6; k++)
		begin
			ref_wave <= {1'b0, k == 4, 2'h0};
			cfg(16'(k << 4), 16'h0100);
			#1;
			`CHK(c_out[2], 1'(k == 5))
		end
		close_out();
	end
endmodule // capture_compare_channel_config_test
